/* ast_pkg.sv */
// constants and carrier types for the alarm, status and temperature registers
package ast_pkg;
  // register addresses on the serial control interface
  localparam logic [4:0] ADDR_TEMPERATURE_RESULT = 5'h05;
  localparam logic [4:0] ADDR_ALARM_PIN_MASK = 5'h06;
  localparam logic [4:0] ADDR_ALARM_STATUS = 5'h07;
  localparam logic [4:0] ADDR_PATTERN_FAIL_BITS = 5'h08;
  // reset values
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FAIL_RESET = 8'h00;
  // alarm bit positions, shared by mask and status
  localparam int BIT_ZERO_PTR = 6;
  localparam int BIT_COLLISION = 5;
  localparam int BIT_PATTERN = 3;
  localparam int BIT_NEAR_TWO = 1;
  localparam int BIT_NEAR_ONE = 0;
  // status bits that can ever be set
  localparam logic [7:0] STATUS_LIVE = 8'h6B;
  // serial frame layout: 8 header bits then 8 data bits
  localparam int HDR_BITS = 8;
  localparam int FRAME_BITS = 16;
  localparam int HDR_READ_BIT = 7;
  // fifo write pointer value and read pointer offset after reset
  localparam logic [7:0] WR_PTR_RESET = 8'h01;
  localparam logic [2:0] RD_OFFSET_RESET = 3'h4;
  // consecutive good samples before alarms clear themselves
  localparam logic [6:0] AUTO_CLEAR_COUNT = 7'h40;
  // serial interface pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic sdenb_n;
    logic sdio;
  } ast_sif_in_s;
  typedef logic [7:0] ast_word_t;
endpackage

/* ast_alarm_regs.sv */
// alarm mask, latched alarm status, pattern results and temperature registers
`timescale 1ns/1ps
// Contract
// - temperature register read-only, signed Celsius byte
// - masked alarms never drive the alarm pin
// - mask bits 6,5,3,1,0 map to alarms
// - mask zero unmasks, one masks; reset zero
// - all-zeros write pointer sets bit 6
// - zero write pointer stays stuck until sync
// - pointer overrun or underrun sets bit 5
// - pattern mismatch sets status bit 3
// - pointers within two addresses set bit 1
// - pointers within one address set bit 0
// - status resets zero, host write clears it
// - fail register flags each failing bit position
// - fail register resets zero, write clears it
// - near alarms need their enable settings
// - auto-clear after 64 consecutive good samples
// - checker runs when enabled, eight pattern words
module ast_alarm_regs
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ast_pkg::ast_sif_in_s sif_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic alarm_out_pin,
  input wire ast_pkg::ast_word_t temp_code,
  input wire logic fifo_sync,
  input wire ast_pkg::ast_word_t wr_ptr_seed,
  input wire logic [2:0] rd_offset,
  input wire logic wr_advance,
  input wire logic rd_advance,
  input wire logic near_two_enable,
  input wire logic near_one_enable,
  input wire logic auto_clear_enable,
  input wire logic pattern_check_enable,
  input wire logic [7:0][7:0] pattern_words,
  input wire ast_pkg::ast_word_t data_in,
  input wire logic data_valid
);
  import ast_pkg::*;

  // position of the set bit in a one-hot pointer
  function automatic logic [2:0] ast_onehot_idx(input logic [7:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (p[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // circular distance test used for both near alarms
  function automatic logic ast_within(input logic [2:0] d,
                                      input logic [2:0] n);
    return (d == n) || (d == 3'(3'h0 - n));
  endfunction

  logic sclk_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] hdr_reg;
  logic [7:0] wdat_reg;
  logic [7:0] rd_sh_reg;
  logic sdio_out_reg;
  logic sdio_oe_reg;
  logic [6:0] mask_reg;
  logic [7:0] status_reg;
  logic [7:0] fail_reg;
  logic [7:0] temp_reg;
  logic [7:0] wr_ptr_reg;
  logic [7:0] rd_ptr_reg;
  logic [2:0] pat_idx_reg;
  logic [6:0] good_cnt_reg;
  logic alarm_reg;

  // serial clock edges; pins are synchronous to clk so no synchroniser
  wire sclk_rise = sif_in.sclk & ~sclk_reg;
  wire sclk_fall = ~sif_in.sclk & sclk_reg;
  wire frame_on = ~sif_in.sdenb_n;
  wire in_hdr = bit_cnt_reg < 5'(HDR_BITS);
  wire in_data = !in_hdr && (bit_cnt_reg < 5'(FRAME_BITS));
  wire is_read = hdr_reg[HDR_READ_BIT];
  wire [4:0] addr = hdr_reg[4:0];
  wire last_rise = frame_on && sclk_rise
                   && (bit_cnt_reg == 5'(FRAME_BITS - 1));
  wire host_write = last_rise && !is_read;
  wire [7:0] write_data = {wdat_reg[6:0], sif_in.sdio};

  // register read selection; unmapped addresses read zero
  // temperature read only
  wire [7:0] read_value =
    (addr == ADDR_TEMPERATURE_RESULT) ? temp_reg :
    (addr == ADDR_ALARM_PIN_MASK) ? {1'b0, mask_reg} :
    (addr == ADDR_ALARM_STATUS) ? status_reg :
    (addr == ADDR_PATTERN_FAIL_BITS) ? fail_reg : 8'h00;

  // frame bit counter and header / write data shifters
  always_ff @(posedge clk)
  begin
    if (rst || !frame_on)
    begin
      bit_cnt_reg <= 5'h00;
    end
    else if (sclk_rise && bit_cnt_reg != 5'(FRAME_BITS))
    begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_reg <= 1'b0;
      hdr_reg <= 8'h00;
      wdat_reg <= 8'h00;
    end
    else
    begin
      sclk_reg <= sif_in.sclk;
      if (frame_on && sclk_rise && in_hdr)
      begin
        hdr_reg <= {hdr_reg[6:0], sif_in.sdio};
      end
      if (frame_on && sclk_rise && in_data)
      begin
        wdat_reg <= write_data;
      end
    end
  end

  // read data leaves on falling edges so the host samples on rising ones
  always_ff @(posedge clk)
  begin
    if (rst || !frame_on)
    begin
      rd_sh_reg <= 8'h00;
      sdio_out_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end
    else if (sclk_fall && bit_cnt_reg == 5'(HDR_BITS))
    begin
      rd_sh_reg <= {read_value[6:0], 1'b0};
      sdio_out_reg <= read_value[7];
      sdio_oe_reg <= is_read;
    end
    else if (sclk_fall && in_data)
    begin
      rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
      sdio_out_reg <= rd_sh_reg[7];
    end
    else if (sclk_fall && bit_cnt_reg == 5'(FRAME_BITS))
    begin
      sdio_oe_reg <= 1'b0;
    end
  end

  // temperature is frozen during a frame so a read returns one sample
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      temp_reg <= 8'h00;
    end
    else if (!frame_on)
    begin
      temp_reg <= temp_code;
    end
  end

  // mask register, seven bits, bit 7 reads zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_reg <= MASK_RESET;
    end
    else if (host_write && addr == ADDR_ALARM_PIN_MASK)
    begin
      mask_reg <= write_data[6:0];
    end
  end

  // fifo pointers as one-hot shift registers
  // zero pointer stuck
  wire wr_ptr_zero = (wr_ptr_reg == 8'h00);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= WR_PTR_RESET;
      rd_ptr_reg <= 8'h01 << RD_OFFSET_RESET;
    end
    else if (fifo_sync)
    begin
      wr_ptr_reg <= wr_ptr_seed;
      rd_ptr_reg <= 8'h01 << rd_offset;
    end
    else
    begin
      if (wr_advance && !wr_ptr_zero)
      begin
        wr_ptr_reg <= {wr_ptr_reg[6:0], wr_ptr_reg[7]};
      end
      if (rd_advance)
      begin
        rd_ptr_reg <= {rd_ptr_reg[6:0], rd_ptr_reg[7]};
      end
    end
  end

  // pointer distance, write minus read, modulo eight
  wire [2:0] ptr_dist = ast_onehot_idx(wr_ptr_reg)
                        - ast_onehot_idx(rd_ptr_reg);
  wire ev_collision = !wr_ptr_zero && ptr_dist == 3'h0
                      && (wr_advance || rd_advance);
  wire ev_near_two = near_two_enable && !wr_ptr_zero
                     && ast_within(ptr_dist, 3'h2);
  wire ev_near_one = near_one_enable && !wr_ptr_zero
                     && ast_within(ptr_dist, 3'h1);

  // pattern checker walks the eight words in order
  // enabled eight words
  wire pat_active = pattern_check_enable && data_valid;
  wire [7:0] pat_diff = pat_active
                        ? (data_in ^ pattern_words[pat_idx_reg]) : 8'h00;
  wire ev_pattern = |pat_diff;
  always_ff @(posedge clk)
  begin
    if (rst || !pattern_check_enable)
    begin
      pat_idx_reg <= 3'h0;
    end
    else if (data_valid)
    begin
      pat_idx_reg <= pat_idx_reg + 3'h1;
    end
  end

  // good-sample run length; any alarm event restarts the run
  wire any_event = wr_ptr_zero || ev_collision || ev_pattern
                   || ev_near_two || ev_near_one;
  wire auto_clear = auto_clear_enable && data_valid && !any_event
                    && good_cnt_reg == AUTO_CLEAR_COUNT - 7'h01;
  always_ff @(posedge clk)
  begin
    if (rst || !auto_clear_enable || any_event || auto_clear)
    begin
      good_cnt_reg <= 7'h00;
    end
    else if (data_valid)
    begin
      good_cnt_reg <= good_cnt_reg + 7'h01;
    end
  end

  // new alarm events; bits 7, 4 and 2 carry none
  // bit map
  logic [7:0] status_set;
  always_comb
  begin
    status_set = 8'h00;
    status_set[BIT_ZERO_PTR] = wr_ptr_zero;
    status_set[BIT_COLLISION] = ev_collision;
    status_set[BIT_PATTERN] = ev_pattern;
    status_set[BIT_NEAR_TWO] = ev_near_two;
    status_set[BIT_NEAR_ONE] = ev_near_one;
  end

  // clears from host write or auto-clear; a set in the same cycle wins
  // write clears status
  wire status_clr = auto_clear
                    || (host_write && addr == ADDR_ALARM_STATUS);
  wire fail_clr = auto_clear
                  || (host_write && addr == ADDR_PATTERN_FAIL_BITS);
  wire [7:0] status_next = ((status_clr ? 8'h00 : status_reg)
                            | status_set) & STATUS_LIVE;
  wire [7:0] fail_next = (fail_clr ? 8'h00 : fail_reg) | pat_diff;

  // latched flags
  // latched until cleared
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_reg <= STATUS_RESET;
      fail_reg <= FAIL_RESET;
    end
    else
    begin
      status_reg <= status_next;
      fail_reg <= fail_next;
    end
  end

  // alarm pin follows the latched flags one cycle later
  // mask blocks pin
  wire alarm_next = |(status_reg[6:0] & ~mask_reg);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm_reg <= 1'b0;
    end
    else
    begin
      alarm_reg <= alarm_next;
    end
  end

  assign alarm_out_pin = alarm_reg;
  assign sdio_out = sdio_out_reg;
  assign sdio_oe = sdio_oe_reg;
endmodule // ast_alarm_regs

/* ast_alarm_regs_asserts.sv */
// checker on the alarm register block ports
`timescale 1ns/1ps
module ast_chk
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ast_pkg::ast_sif_in_s sif_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic alarm_out_pin,
  input wire logic fifo_sync,
  input wire logic wr_advance,
  input wire logic rd_advance,
  input wire logic near_two_enable,
  input wire logic near_one_enable,
  input wire logic auto_clear_enable,
  input wire logic data_valid
);
  // anything that may set a flag, or unmask one through a frame
  wire cause = data_valid | wr_advance | rd_advance | fifo_sync |
    near_two_enable | near_one_enable | ~sif_in.sdenb_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !alarm_out_pin && !sdio_oe) else $error("busy after reset");
  a_pin_holds: assert property (alarm_out_pin && sif_in.sdenb_n &&
    $past(sif_in.sdenb_n) && !auto_clear_enable |=> alarm_out_pin)
    else $error("alarm pin dropped without a clear");
  a_pin_cause: assert property ($rose(alarm_out_pin) |->
    $past(cause, 2) || $past(cause, 3) || $past(cause, 4))
    else $error("alarm pin rose without a cause");
  a_oe_idle: assert property (
    sif_in.sdenb_n ##1 sif_in.sdenb_n |-> !sdio_oe)
    else $error("sdio driven outside a frame");
  a_oe_frame: assert property (
    sdio_oe |-> !$past(sif_in.sdenb_n, 2)) else $error("sdio driven late");
  a_oe_rise: assert property ($rose(sdio_oe) |->
    $past(sif_in.sclk, 2) && !$past(sif_in.sclk) ||
    $past(sif_in.sclk, 3) && !$past(sif_in.sclk, 2))
    else $error("sdio drive not after a clock fall");
  a_out_fall: assert property (sdio_oe && $changed(sdio_out) |->
    $past(sif_in.sclk, 2) && !$past(sif_in.sclk) ||
    $past(sif_in.sclk, 3) && !$past(sif_in.sclk, 2))
    else $error("read bit not after a clock fall");
  a_oe_release: assert property ($fell(sdio_oe) |->
    !sif_in.sclk || $past(sif_in.sdenb_n)) else $error("bad release");
endmodule // ast_chk

bind ast_alarm_regs ast_chk i_chk (.clk, .rst, .sif_in, .sdio_out,
  .sdio_oe, .alarm_out_pin, .fifo_sync, .wr_advance, .rd_advance,
  .near_two_enable, .near_one_enable, .auto_clear_enable, .data_valid);

/* ast_host.sv */
// host model driving the serial control interface
`timescale 1ns/1ps
module ast_host
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output ast_pkg::ast_sif_in_s sif
);
  logic sclk_r = 1'b0;
  logic en_n_r = 1'b1;
  logic dat_r = 1'b0;
  // shared data wire: the device wins while it drives
  assign sif = '{sclk_r, en_n_r, sdio_oe ? sdio_out : dat_r};
  // one frame, msb first; sclk idles low outside frames
  task automatic xfer(input logic rd, input logic [4:0] a,
    input ast_word_t wd, input int h, output ast_word_t q);
    logic [15:0] f;
    f = {rd, 2'b00, a, wd};
    q = '0;
    @(negedge clk);
    en_n_r <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge clk);
      sclk_r <= 1'b0;
      // released on read data: toggle so a stale level never reads right
      dat_r <= (rd && i < 8) ? ~dat_r : f[i];
      repeat (h) @(negedge clk);
      sclk_r <= 1'b1;
      q = {q[6:0], sif.sdio};
      repeat (h - 1) @(negedge clk);
    end
    @(negedge clk);
    sclk_r <= 1'b0;
    repeat (h) @(negedge clk);
    en_n_r <= 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule // ast_host

/* testbench.sv */
// self-checking bench for the alarm and status registers
`timescale 1ns/1ps
module testbench;
  import ast_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ast_sif_in_s sif_in;
  logic sdio_out, sdio_oe, alarm_out_pin;
  ast_word_t temp_code = 8'hE7;
  logic fifo_sync = 1'b0;
  logic wr_advance = 1'b0;
  logic rd_advance = 1'b0;
  logic pattern_check_enable = 1'b1;
  ast_word_t wr_ptr_seed = 8'h01;
  logic [2:0] rd_offset = 3'h4;
  logic near_two_enable = 1'b0;
  logic near_one_enable = 1'b0;
  logic auto_clear_enable = 1'b0;
  logic [7:0][7:0] pattern_words = 64'hC6AA_161A_45EA_B67A;
  ast_word_t data_in = 8'h00;
  logic data_valid = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;
  int pidx = 0;
  initial forever #12.5 clk = ~clk;
  // every control input is bench driven so each rule can be exercised
  ast_alarm_regs i_dut (.clk, .rst, .sif_in, .sdio_out, .sdio_oe,
    .alarm_out_pin, .temp_code, .fifo_sync, .wr_ptr_seed, .rd_offset,
    .wr_advance, .rd_advance, .near_two_enable, .near_one_enable,
    .auto_clear_enable, .pattern_check_enable, .pattern_words,
    .data_in, .data_valid);
  ast_host i_host (.clk, .sdio_out, .sdio_oe, .sif(sif_in));
  task automatic chk(input ast_word_t got, input ast_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input ast_word_t d);
    ast_word_t q;
    i_host.xfer(1'b0, a, d, 2, q);
  endtask
  task automatic rdc(input logic [4:0] a, input ast_word_t e, input int h);
    ast_word_t q;
    i_host.xfer(1'b1, a, 8'h00, h, q);
    chk(q, e);
  endtask
  // n samples in pattern order, the first one spoiled by e
  task automatic smp(input int n, input ast_word_t e);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      data_valid <= 1'b1;
      data_in <= pattern_words[pidx] ^ (i == 0 ? e : 8'h00);
      pidx = (pidx + 1) % 8;
    end
    @(negedge clk);
    data_valid <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic sync(input ast_word_t s, input logic [2:0] o);
    @(negedge clk);
    fifo_sync <= 1'b1;
    wr_ptr_seed <= s;
    rd_offset <= o;
    @(negedge clk);
    fifo_sync <= 1'b0;
  endtask
  task automatic t_reset();
    logic [4:0] a[4] = '{ADDR_ALARM_PIN_MASK, ADDR_ALARM_STATUS,
      ADDR_PATTERN_FAIL_BITS, 5'h1F};
    foreach (a[i]) rdc(a[i], 8'h00, 2);
  endtask
  task automatic t_regs();
    rdc(ADDR_TEMPERATURE_RESULT, 8'hE7, 20);
    wr(ADDR_TEMPERATURE_RESULT, 8'h11);
    rdc(ADDR_TEMPERATURE_RESULT, 8'hE7, 20);
    wr(ADDR_ALARM_PIN_MASK, 8'hFF);
    rdc(ADDR_ALARM_PIN_MASK, 8'h7F, 2);
  endtask
  task automatic t_pattern();
    wr(ADDR_ALARM_PIN_MASK, 8'h00);
    smp(3, 8'h81);
    chk({7'h0, alarm_out_pin}, 8'h01);
    rdc(ADDR_ALARM_STATUS, 8'h08, 2);
    rdc(ADDR_PATTERN_FAIL_BITS, 8'h81, 2);
    wr(ADDR_ALARM_STATUS, 8'h00);
    wr(ADDR_PATTERN_FAIL_BITS, 8'hFF);
    rdc(ADDR_ALARM_STATUS, 8'h00, 2);
    rdc(ADDR_PATTERN_FAIL_BITS, 8'h00, 2);
    chk({7'h0, alarm_out_pin}, 8'h00);
    wr(ADDR_ALARM_PIN_MASK, 8'h08);
    smp(1, 8'h04);
    chk({7'h0, alarm_out_pin}, 8'h00);
    rdc(ADDR_ALARM_STATUS, 8'h08, 2);
    wr(ADDR_ALARM_PIN_MASK, 8'h77);
    chk({7'h0, alarm_out_pin}, 8'h01);
    wr(ADDR_ALARM_PIN_MASK, 8'h00);
    wr(ADDR_ALARM_STATUS, 8'h00);
  endtask
  task automatic t_zero();
    sync(8'h00, 3'h4);
    rdc(ADDR_ALARM_STATUS, 8'h40, 2);
    wr(ADDR_ALARM_STATUS, 8'h00);
    rdc(ADDR_ALARM_STATUS, 8'h40, 2);
    sync(8'h01, 3'h4);
    wr(ADDR_ALARM_STATUS, 8'h00);
    rdc(ADDR_ALARM_STATUS, 8'h00, 2);
  endtask
  // entries: read offset, enables, write advance, expected status
  task automatic t_near();
    logic [12:0] tbl[5] = '{13'h0800, 13'h0A02, 13'h0601, 13'h0321,
      13'h1200};
    logic [2:0] off;
    logic en;
    logic adv;
    ast_word_t e;
    foreach (tbl[i])
    begin
      {off, en, adv, e} = tbl[i];
      near_two_enable <= en;
      near_one_enable <= en;
      sync(8'h01, off);
      wr(ADDR_ALARM_STATUS, 8'h00);
      wr_advance <= adv;
      @(negedge clk);
      wr_advance <= 1'b0;
      rdc(ADDR_ALARM_STATUS, e, 2);
    end
    // read side overrun: equal pointers, read advance only
    near_two_enable <= 1'b0;
    near_one_enable <= 1'b0;
    sync(8'h01, 3'h0);
    wr(ADDR_ALARM_STATUS, 8'h00);
    rd_advance <= 1'b1;
    @(negedge clk);
    rd_advance <= 1'b0;
    rdc(ADDR_ALARM_STATUS, 8'h20, 2);
    sync(8'h01, 3'h4);
    wr(ADDR_ALARM_STATUS, 8'h00);
    rdc(ADDR_ALARM_STATUS, 8'h00, 2);
  endtask
  task automatic t_auto();
    auto_clear_enable <= 1'b1;
    smp(1, 8'h10);
    smp(63, 8'h00);
    chk({7'h0, alarm_out_pin}, 8'h01);
    smp(1, 8'h10);
    smp(64, 8'h00);
    chk({7'h0, alarm_out_pin}, 8'h00);
    rdc(ADDR_PATTERN_FAIL_BITS, 8'h00, 2);
  endtask
  // checker off: spoiled samples flag nothing, word order restarts
  task automatic t_off();
    pattern_check_enable <= 1'b0;
    smp(2, 8'hFF);
    rdc(ADDR_PATTERN_FAIL_BITS, 8'h00, 2);
    rdc(ADDR_ALARM_STATUS, 8'h00, 2);
    pattern_check_enable <= 1'b1;
    pidx = 0;
    smp(2, 8'h00);
    rdc(ADDR_PATTERN_FAIL_BITS, 8'h00, 2);
    rdc(ADDR_ALARM_STATUS, 8'h00, 2);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_pattern();
    t_zero();
    t_near();
    t_auto();
    t_off();
    complete_run();
  end
  // hang guard, several times the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule // testbench
